// file: verilog/data_memory_bank.sv
module data_memory_bank
    import dm_pkg::*;
#(
    parameter int NUM_BANKS = dm_pkg::NUM_BANKS,
    parameter int BANK_BYTES = dm_pkg::BANK_BYTES,
    parameter logic [7:0] DISP_LAST = dm_pkg::DISP_LAST
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic acc_valid,
    input wire logic acc_write,
    input wire dm_pkg::byte_t acc_addr,
    input wire dm_pkg::byte_t acc_wdata,
    input wire logic warm_reset,
    input wire logic warm_reset_wdt_pd,
    output dm_pkg::byte_t acc_rdata,
    output logic acc_rvalid,
    output dm_pkg::byte_t cur_bank
);
    import dm_pkg::*;

    localparam int DEPTH = NUM_BANKS * BANK_BYTES;
    localparam int IDX_W = $clog2(DEPTH);

    logic rst_s1_q;
    logic rst_s2_q;
    wire logic rst_n = rst_s2_q;

    byte_t ptr0_q;
    byte_t ptr1_q;
    byte_t bank_q;
    byte_t ptr0_d;
    byte_t ptr1_d;
    byte_t bank_d;

    logic s1_valid_q;
    rd_src_e s1_src_q;
    byte_t s1_sfr_q;
    byte_t rdata_q;
    logic rvalid_q;

    byte_t off;
    logic to_sfr;
    logic to_ram;
    logic [IDX_W-1:0] ram_idx;

    ram_port_if #(.IDX_W(IDX_W)) ram_bus ();

    // reset release through two flops
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end
        else
        begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end

    addr_decode #(
        .NUM_BANKS(NUM_BANKS),
        .BANK_BYTES(BANK_BYTES),
        .IDX_W(IDX_W)
    ) u_decode (
        .addr(acc_addr),
        .ptr0(ptr0_q),
        .ptr1(ptr1_q),
        .bank(bank_q),
        .disp_last(DISP_LAST),
        .off(off),
        .to_sfr(to_sfr),
        .to_ram(to_ram),
        .ram_idx(ram_idx)
    );

    gp_ram #(
        .NUM_BANKS(NUM_BANKS),
        .BANK_BYTES(BANK_BYTES),
        .IDX_W(IDX_W)
    ) u_ram (
        .sys_clk(sys_clk),
        .ce(ce),
        .port(ram_bus)
    );

    // request qualifiers
    wire logic req = acc_valid;
    wire logic req_wr = req && acc_write;
    wire logic req_rd = req && !acc_write;

    // general area access: bank 1 includes display storage
    assign ram_bus.en = req && to_ram;
    assign ram_bus.we = req_wr && to_ram;
    assign ram_bus.idx = ram_idx;
    assign ram_bus.wdata = acc_wdata;

    // special-area writes land on the same register from any bank
    wire logic sfr_wr = req_wr && to_sfr;
    wire logic wr_ptr0 = sfr_wr && (off == OFF_PTR0);
    wire logic wr_ptr1 = sfr_wr && (off == OFF_PTR1);
    wire logic wr_bank = sfr_wr && (off == OFF_BANK);
    wire logic bank_clear = warm_reset && !warm_reset_wdt_pd;

    assign ptr0_d = wr_ptr0 ? acc_wdata : ptr0_q;
    assign ptr1_d = wr_ptr1 ? acc_wdata : ptr1_q;
    assign bank_d = bank_clear ? RST_BANK :
        (wr_bank ? acc_wdata : bank_q);

    // special-area read value; ports and unused locations give zero
    byte_t sfr_rd;
    always_comb
    begin
        sfr_rd = READ_ZERO;
        if (off == OFF_PTR0)
        begin
            sfr_rd = ptr0_q;
        end
        else if (off == OFF_PTR1)
        begin
            sfr_rd = ptr1_q;
        end
        else if (off == OFF_BANK)
        begin
            sfr_rd = bank_q;
        end
    end

    // where the read answer comes from
    rd_src_e rd_src;
    assign rd_src = to_ram ? SRC_RAM :
        (to_sfr ? SRC_SFR : SRC_ZERO);

    // owned registers
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ptr0_q <= RST_PTR;
            ptr1_q <= RST_PTR;
            bank_q <= RST_BANK;
        end
        else if (ce)
        begin
            ptr0_q <= ptr0_d;
            ptr1_q <= ptr1_d;
            bank_q <= bank_d;
        end
    end

    // first read stage, alongside the memory read
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1_valid_q <= 1'b0;
            s1_src_q <= SRC_ZERO;
            s1_sfr_q <= READ_ZERO;
        end
        else if (ce)
        begin
            s1_valid_q <= req_rd;
            s1_src_q <= rd_src;
            s1_sfr_q <= sfr_rd;
        end
    end

    // answer selection
    byte_t ans;
    always_comb
    begin
        ans = READ_ZERO;
        unique case (s1_src_q)
            SRC_RAM:
            begin
                ans = ram_bus.rdata;
            end
            SRC_SFR:
            begin
                ans = s1_sfr_q;
            end
            SRC_ZERO:
            begin
                ans = READ_ZERO;
            end
        endcase
    end

    // second stage: registered answer
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdata_q <= READ_ZERO;
            rvalid_q <= 1'b0;
        end
        else if (ce)
        begin
            rvalid_q <= s1_valid_q;
            rdata_q <= s1_valid_q ? ans : READ_ZERO;
        end
    end

    assign acc_rdata = rdata_q;
    assign acc_rvalid = rvalid_q;
    assign cur_bank = bank_q;
endmodule : data_memory_bank

// file: verilog/dm_pkg.sv
package dm_pkg;
    // locations owned by this block
    localparam logic [7:0] OFF_PORT0 = 8'h00;
    localparam logic [7:0] OFF_PTR0 = 8'h01;
    localparam logic [7:0] OFF_PORT1 = 8'h02;
    localparam logic [7:0] OFF_PTR1 = 8'h03;
    localparam logic [7:0] OFF_BANK = 8'h04;
    // area limits
    localparam logic [7:0] SPA_LAST = 8'h3f;
    localparam logic [7:0] GPA_START = 8'h40;
    localparam logic [7:0] GPA_LAST = 8'hff;
    localparam logic [7:0] DISP_LAST = 8'h70;
    localparam logic [7:0] DISP_BANK = 8'h01;
    localparam logic [7:0] BANK_ZERO = 8'h00;
    localparam int NUM_BANKS = 7;
    localparam int BANK_BYTES = 192;
    // reset values
    localparam logic [7:0] RST_PTR = 8'h00;
    localparam logic [7:0] RST_BANK = 8'h00;
    localparam logic [7:0] READ_ZERO = 8'h00;
    // cycles from request to read answer
    localparam int READ_LATENCY = 2;
    typedef logic [7:0] byte_t;
    typedef enum logic [1:0] {
        SRC_ZERO,
        SRC_SFR,
        SRC_RAM
    } rd_src_e;
endpackage : dm_pkg

// file: verilog/ram_port_if.sv
interface ram_port_if #(
    parameter int IDX_W = 11
);
    logic en;
    logic we;
    logic [IDX_W-1:0] idx;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport host (
        output en,
        output we,
        output idx,
        output wdata,
        input rdata
    );
    modport mem (
        input en,
        input we,
        input idx,
        input wdata,
        output rdata
    );
endinterface : ram_port_if

// file: verilog/gp_ram.sv
module gp_ram #(
    parameter int NUM_BANKS = 7,
    parameter int BANK_BYTES = 192,
    parameter int IDX_W = 11
) (
    input wire logic sys_clk,
    input wire logic ce,
    ram_port_if.mem port
);
    localparam int DEPTH = NUM_BANKS * BANK_BYTES;

    logic [7:0] mem_q [DEPTH];
    logic [7:0] rdata_q;

    // general-purpose and display storage, one cycle read
    always_ff @(posedge sys_clk)
    begin
        if (ce && port.en)
        begin
            if (port.we)
            begin
                mem_q[port.idx] <= port.wdata;
            end
            rdata_q <= mem_q[port.idx];
        end
    end

    assign port.rdata = rdata_q;
endmodule : gp_ram

// file: verilog/addr_decode.sv
module addr_decode
    import dm_pkg::*;
#(
    parameter int NUM_BANKS = 7,
    parameter int BANK_BYTES = 192,
    parameter int IDX_W = 11
) (
    input wire dm_pkg::byte_t addr,
    input wire dm_pkg::byte_t ptr0,
    input wire dm_pkg::byte_t ptr1,
    input wire dm_pkg::byte_t bank,
    input wire dm_pkg::byte_t disp_last,
    output dm_pkg::byte_t off,
    output logic to_sfr,
    output logic to_ram,
    output logic [IDX_W-1:0] ram_idx
);
    wire via0 = (addr == OFF_PORT0);
    wire via1 = (addr == OFF_PORT1);
    wire indirect = via0 || via1;
    wire byte_t eff_bank;
    wire tgt_port;
    wire in_spa;
    wire over_disp;
    wire no_bank;
    wire [IDX_W-1:0] bank_base;
    wire [IDX_W-1:0] in_bank;

    // port access is redirected to its pointer
    assign off = via0 ? ptr0 : (via1 ? ptr1 : addr);
    // direct and port zero stay in bank 0, port one follows selector
    assign eff_bank = via1 ? bank : BANK_ZERO;
    assign tgt_port = indirect &&
        ((off == OFF_PORT0) || (off == OFF_PORT1));
    // special area is common to every bank
    assign in_spa = (off <= SPA_LAST);
    assign over_disp = (eff_bank == DISP_BANK) && (off > disp_last);
    assign no_bank = (eff_bank >= 8'(NUM_BANKS));
    assign to_sfr = in_spa && !tgt_port;
    assign to_ram = !in_spa && !over_disp && !no_bank;
    assign bank_base = IDX_W'(eff_bank) * IDX_W'(BANK_BYTES);
    assign in_bank = IDX_W'(off - GPA_START);
    assign ram_idx = bank_base + in_bank;
endmodule : addr_decode

// file: tb/dm_chk.sv
module dm_chk
    import dm_pkg::*;
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic acc_valid,
    input wire logic acc_write,
    input wire dm_pkg::byte_t acc_addr,
    input wire dm_pkg::byte_t acc_wdata,
    input wire logic warm_reset,
    input wire logic warm_reset_wdt_pd,
    input wire dm_pkg::byte_t acc_rdata,
    input wire logic acc_rvalid,
    input wire dm_pkg::byte_t cur_bank
);
    timeunit 1ns;
    timeprecision 1ps;
    wire logic rd_req = acc_valid && !acc_write;
    wire logic wr_req = acc_valid && acc_write;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn || !ce);
    a_read_answer: assert property (rd_req |-> ##2 acc_rvalid)
        else $error("read not answered");
    a_no_spurious: assert property (acc_rvalid |-> $past(rd_req, 2))
        else $error("answer without read");
    a_idle_zero: assert property (!acc_rvalid |-> acc_rdata == 8'h00)
        else $error("data outside answer");
    a_unused_zero: assert property (rd_req && acc_addr >= 8'h05 &&
        acc_addr <= 8'h3f |-> ##2 acc_rdata == 8'h00)
        else $error("unused place not zero");
    a_bank_write: assert property (wr_req && acc_addr == 8'h04 &&
        !warm_reset |=> cur_bank == $past(acc_wdata))
        else $error("bank not written");
    a_bank_cause: assert property (!$stable(cur_bank) |->
        $past(wr_req && acc_addr <= 8'h04 || warm_reset))
        else $error("bank changed alone");
    a_warm_clear: assert property (warm_reset &&
        !warm_reset_wdt_pd |=> cur_bank == 8'h00)
        else $error("bank not cleared");
    a_wdt_keep: assert property (warm_reset && warm_reset_wdt_pd &&
        !acc_valid |=> $stable(cur_bank))
        else $error("bank lost");
endmodule : dm_chk

// file: tb/cpu_model.sv
module cpu_model
    import dm_pkg::*;
(
    input wire logic sys_clk,
    input wire dm_pkg::byte_t acc_rdata,
    input wire logic acc_rvalid,
    output logic acc_valid = 1'b0,
    output logic acc_write = 1'b0,
    output dm_pkg::byte_t acc_addr = 8'h5a,
    output dm_pkg::byte_t acc_wdata = 8'ha5
);
    timeunit 1ns;
    timeprecision 1ps;
    // one access, entered just after a rising edge
    task automatic xfer(input logic w, input byte_t a, input byte_t d,
        output byte_t q);
        int n;
        q = 'x;
        acc_valid <= 1'b1;
        acc_write <= w;
        acc_addr <= a;
        acc_wdata <= d;
        @(posedge sys_clk);
        acc_valid <= 1'b0;
        acc_addr <= ~a;
        acc_wdata <= ~d;
        // a write lets one edge pass so the next call never reassigns now
        if (w)
        begin
            @(posedge sys_clk);
        end
        for (n = 0; n < 4 && !w; n++)
        begin
            @(negedge sys_clk);
            if (acc_rvalid === 1'b1)
                break;
        end
        if (n == 4)
        begin
            data_memory_bank_tb.miscompares++;
            data_memory_bank_tb.tally_and_finish();
        end
        if (!w)
        begin
            q = acc_rdata;
            @(posedge sys_clk);
        end
    endtask : xfer
endmodule : cpu_model

// file: tb/data_memory_bank_tb.sv
module data_memory_bank_tb
    import dm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic warm_reset = 1'b0;
    logic warm_reset_wdt_pd = 1'b0;
    logic ce = 1'b1;
    logic acc_valid;
    logic acc_write;
    logic acc_rvalid;
    byte_t acc_addr;
    byte_t acc_wdata;
    byte_t acc_rdata;
    byte_t cur_bank;
    int miscompares = 0;
    int checked = 0;
    always #4 sys_clk = ~sys_clk;
    data_memory_bank DUT (.sys_clk(sys_clk), .resetn(resetn), .ce(ce),
        .acc_valid(acc_valid), .acc_write(acc_write), .acc_addr(acc_addr),
        .acc_wdata(acc_wdata), .warm_reset(warm_reset),
        .warm_reset_wdt_pd(warm_reset_wdt_pd), .acc_rdata(acc_rdata),
        .acc_rvalid(acc_rvalid), .cur_bank(cur_bank));
    cpu_model cpu (.sys_clk(sys_clk), .acc_rdata(acc_rdata),
        .acc_rvalid(acc_rvalid), .acc_valid(acc_valid),
        .acc_write(acc_write), .acc_addr(acc_addr), .acc_wdata(acc_wdata));
    task automatic chk(input byte_t seen, input byte_t exp);
        checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input byte_t a, input byte_t d);
        byte_t v;
        cpu.xfer(1'b1, a, d, v);
    endtask : wr
    task automatic rc(input byte_t a, input byte_t e);
        byte_t v;
        cpu.xfer(1'b0, a, 8'h00, v);
        chk(v, e);
    endtask : rc
    task automatic t_regs;
        byte_t u[4] = '{8'h05, 8'h0c, 8'h3d, 8'h3e};
        rc(8'h04, 8'h00);
        wr(8'h01, 8'h55);
        wr(8'h03, 8'haa);
        wr(8'h3e, 8'hff);
        rc(8'h01, 8'h55);
        rc(8'h03, 8'haa);
        foreach (u[i]) rc(u[i], 8'h00);
    endtask : t_regs
    task automatic t_indirect;
        wr(8'h01, 8'h40);
        wr(8'h00, 8'h11);
        rc(8'h40, 8'h11);
        wr(8'h04, 8'h02);
        wr(8'h03, 8'h40);
        wr(8'h02, 8'h22);
        rc(8'h40, 8'h11);
        rc(8'h02, 8'h22);
        rc(8'h00, 8'h11);
        rc(8'h04, 8'h02);
        wr(8'h01, 8'h02);
        wr(8'h00, 8'h55);
        rc(8'h00, 8'h00);
        rc(8'h03, 8'h40);
    endtask : t_indirect
    task automatic t_freeze;
        ce <= 1'b0;
        wr(8'h01, 8'h3c);
        ce <= 1'b1;
        rc(8'h01, 8'h02);
    endtask : t_freeze
    task automatic t_display;
        wr(8'h70, 8'h77);
        wr(8'h04, 8'h01);
        wr(8'h03, 8'h70);
        wr(8'h02, 8'h33);
        rc(8'h02, 8'h33);
        rc(8'h70, 8'h77);
        wr(8'h03, 8'h71);
        wr(8'h02, 8'h44);
        rc(8'h02, 8'h00);
        wr(8'h03, 8'h04);
        rc(8'h02, 8'h01);
        wr(8'h03, 8'h02);
        wr(8'h02, 8'h99);
        rc(8'h02, 8'h00);
        rc(8'h03, 8'h02);
    endtask : t_display
    task automatic t_warm(input logic pd, input byte_t e);
        warm_reset <= 1'b1;
        warm_reset_wdt_pd <= pd;
        @(posedge sys_clk);
        warm_reset <= 1'b0;
        warm_reset_wdt_pd <= 1'b0;
        @(posedge sys_clk);
        rc(8'h04, e);
    endtask : t_warm
    task automatic tally_and_finish;
        if (miscompares == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : tally_and_finish
    initial
    begin
        repeat (8) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge sys_clk);
        t_regs();
        t_indirect();
        t_display();
        t_freeze();
        t_warm(1'b1, 8'h01);
        t_warm(1'b0, 8'h00);
        tally_and_finish();
    end
endmodule : data_memory_bank_tb
bind data_memory_bank dm_chk chk (.sys_clk(sys_clk), .resetn(resetn),
    .ce(ce), .acc_valid(acc_valid), .acc_write(acc_write),
    .acc_addr(acc_addr), .acc_wdata(acc_wdata), .warm_reset(warm_reset),
    .warm_reset_wdt_pd(warm_reset_wdt_pd), .acc_rdata(acc_rdata),
    .acc_rvalid(acc_rvalid), .cur_bank(cur_bank));
